// ==== pkg/phy_line_pkg.sv ====
// Purpose: Shared constants and code tables for the PHY line coding path
// Assumes: One system clock of 40 MHz; 100M symbol path advances one code bit per cycle
// Notes: Long counts are given as defaults for top-level parameters
package phy_line_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_KHZ = CLK_HZ / 1000;
  // 4B/5B control code groups
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0D;
  localparam logic [4:0] CG_R = 5'h07;
  localparam logic [4:0] CG_I = 5'h1F;
  localparam logic [4:0] CG_H = 5'h04;
  localparam logic [4:0] CG_INVALID = 5'h10;
  localparam logic [3:0] NIB_PREAMBLE = 4'h5;
  localparam logic [3:0] NIB_BAD_SSD = 4'hE;
  localparam logic [2:0] SYM_LAST = 3'h4;
  localparam logic [2:0] MII_CLK_RISE = 3'h2;
  // Scrambler key generator
  localparam logic [10:0] SCR_SEED = 11'h7FF;
  localparam logic [5:0] LOCK_MATCHES = 6'h1E;
  localparam logic [3:0] IDLE_RUN = 4'hA;
  localparam int IDLE_WINDOW_NS = 40_000;
  localparam int IDLE_WINDOW_CYC = IDLE_WINDOW_NS / 1000 * CLK_HZ / 1_000_000;
  localparam int IDLE_TMR_W = 11;
  // MLT-3 slicer and levels
  localparam logic signed [5:0] MLT3_THRESH = 6'sh10;
  localparam logic signed [5:0] MLT3_THRESH_NEG = 6'sh30;
  localparam logic [1:0] LVL_ZERO = 2'h0;
  localparam logic [1:0] LVL_POS = 2'h1;
  localparam logic [1:0] LVL_NEG = 2'h3;
  // 10BASE-T timing
  localparam int NLP_PERIOD_MS = 16;
  localparam int NLP_PERIOD_CYC_DEF = NLP_PERIOD_MS * CLK_KHZ;
  localparam int NLP_WIDTH_NS = 100;
  localparam int NLP_WIDTH_CYC = NLP_WIDTH_NS * CLK_KHZ / 1_000_000;
  localparam int NLP_MAX_NS = 200;
  localparam int NLP_MAX_CYC = NLP_MAX_NS * CLK_KHZ / 1_000_000;
  localparam int JABBER_MS = 45;
  localparam int JABBER_CYC_DEF = JABBER_MS * CLK_KHZ;
  localparam int LINK_LOSS_MS = 100;
  localparam int LINK_LOSS_CYC_DEF = LINK_LOSS_MS * CLK_KHZ;
  localparam logic [3:0] TX10_CLK_HIGH = 4'h8;

  function automatic logic [4:0] enc4b5b(input logic [3:0] nib);
    logic [4:0] tbl [16];
    tbl = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
            5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    return tbl[nib];
  endfunction

  // Returns valid flag and nibble for data code groups
  function automatic logic [4:0] dec5b4b(input logic [4:0] grp);
    logic [4:0] res;
    res = 5'h00;
    for (int i = 0; i < 16; i++)
    begin
      if (enc4b5b(4'(i)) == grp)
      begin
        res = {1'b1, 4'(i)};
      end
    end
    return res;
  endfunction
endpackage

// ==== verilog/tenbase_t_coding.sv ====
// Purpose: 10BASE-T Manchester transmit and receive, link pulses, polarity and jabber
// Assumes: Sliced receive line is synchronous, four cycles per bit, carrier starting one cycle into the first half cell
// Notes: Half-bit cells are two cycles, the 20 MHz cell rate
`timescale 1ns/1ps
module tenbase_t_coding
  import phy_line_pkg::*;
#(
  parameter int NLP_PERIOD_CYC = NLP_PERIOD_CYC_DEF,
  parameter int JABBER_CYC = JABBER_CYC_DEF,
  parameter int LINK_LOSS_CYC = LINK_LOSS_CYC_DEF
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [3:0] txd,
  input wire logic tx_en,
  output logic tx_clk,
  output logic tx_line,
  output logic tx_drive,
  input wire logic rx_line,
  input wire logic rx_active,
  output logic rx_clk,
  output logic [3:0] rxd,
  output logic rx_dv,
  output logic rx_er,
  output logic polarity_reversed_flag,
  output logic link_up,
  output logic jabber
);
  logic [3:0] cyc_q;
  logic [3:0] nib_q;
  logic act_q;
  logic [31:0] jab_q;
  logic [31:0] nlp_tmr_q;
  logic tx_line_q;
  logic tx_drive_q;
  wire nib_take = cyc_q == 4'h0;
  wire jab_hit = jab_q >= 32'(JABBER_CYC);
  // Pulse cut short when a frame is coming, so the receiver sees the frame start
  wire nlp_on = !act_q && !tx_en && nlp_tmr_q < 32'(NLP_WIDTH_CYC);
  wire cur_bit = nib_q[cyc_q[3:2]];
  // First half carries the complement, mid-bit edge carries the bit
  wire man_bit = cyc_q[1] ? cur_bit : !cur_bit;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cyc_q <= 4'h0;
      nib_q <= 4'h0;
      act_q <= 1'b0;
      jab_q <= 32'h0000_0000;
      nlp_tmr_q <= 32'h0000_0000;
      tx_line_q <= 1'b0;
      tx_drive_q <= 1'b0;
    end
    else
    begin
      cyc_q <= cyc_q + 4'h1;
      if (nib_take)
      begin
        nib_q <= txd;
        act_q <= enable && tx_en && !jab_hit;
      end
      jab_q <= !tx_en ? 32'h0000_0000 : (jab_hit ? jab_q : jab_q + 32'h0000_0001);
      // After a frame the next pulse waits a full period instead of joining the frame
      nlp_tmr_q <= act_q ? 32'(NLP_WIDTH_CYC) :
        (nlp_tmr_q >= 32'(NLP_PERIOD_CYC - 1) ? 32'h0000_0000 : nlp_tmr_q + 32'h0000_0001);
      tx_line_q <= act_q ? man_bit : nlp_on;
      tx_drive_q <= enable && (act_q || nlp_on);
    end
  end

  assign tx_clk = cyc_q < TX10_CLK_HIGH;
  assign tx_line = tx_line_q;
  assign tx_drive = tx_drive_q;
  assign jabber = jab_hit;

  logic [1:0] ph_q;
  logic half_a_q;
  logic first_q;
  logic pol_q;
  logic [3:0] sh_q;
  logic [1:0] bcnt_q;
  logic viol_q;
  logic act_d_q;
  logic [3:0] rxd_q;
  logic dv_q;
  logic er_q;
  logic [31:0] plen_q;
  logic [31:0] link_tmr_q;
  wire rx_start = rx_active && !act_d_q;
  // Line starts one cycle into the first half cell: sample cycles 0 and 2 after the rise
  wire bit_done = rx_active && !rx_start && ph_q == 2'h2;
  // Preamble starts with a one; a leading zero means swapped pair
  wire pol_d = first_q ? !rx_line : pol_q;
  wire rx_bit = rx_line ^ pol_d;
  wire viol = half_a_q == rx_line;
  wire nlp_seen = act_d_q && !rx_active && plen_q <= 32'(NLP_MAX_CYC);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ph_q <= 2'h0;
      half_a_q <= 1'b0;
      first_q <= 1'b0;
      pol_q <= 1'b0;
      sh_q <= 4'h0;
      bcnt_q <= 2'h0;
      viol_q <= 1'b0;
      act_d_q <= 1'b0;
      rxd_q <= 4'h0;
      dv_q <= 1'b0;
      er_q <= 1'b0;
      plen_q <= 32'h0000_0000;
      link_tmr_q <= 32'(LINK_LOSS_CYC);
    end
    else
    begin
      act_d_q <= rx_active;
      ph_q <= rx_start ? 2'h1 : ph_q + 2'h1;
      plen_q <= rx_active ? plen_q + 32'h0000_0001 : 32'h0000_0000;
      link_tmr_q <= (nlp_seen || dv_q) ? 32'h0000_0000 :
        (link_tmr_q >= 32'(LINK_LOSS_CYC) ? link_tmr_q : link_tmr_q + 32'h0000_0001);
      if (rx_start)
      begin
        first_q <= 1'b1;
        bcnt_q <= 2'h0;
        viol_q <= 1'b0;
      end
      if (rx_active && (rx_start || ph_q == 2'h0))
      begin
        half_a_q <= rx_line;
      end
      if (bit_done)
      begin
        first_q <= 1'b0;
        pol_q <= pol_d;
        sh_q <= {rx_bit, sh_q[3:1]};
        bcnt_q <= bcnt_q + 2'h1;
        viol_q <= (bcnt_q == 2'h0) ? viol : (viol_q || viol);
        if (bcnt_q == 2'h3)
        begin
          rxd_q <= {rx_bit, sh_q[3:1]};
          dv_q <= enable;
          er_q <= enable && (viol_q || viol);
        end
      end
      else if (!rx_active)
      begin
        dv_q <= 1'b0;
        er_q <= 1'b0;
      end
    end
  end

  // Idle high, so the last nibble of a frame still gets a rising edge
  assign rx_clk = bcnt_q[1] || !rx_active;
  assign rxd = rxd_q;
  assign rx_dv = dv_q;
  assign rx_er = er_q;
  assign polarity_reversed_flag = pol_q;
  assign link_up = link_tmr_q < 32'(LINK_LOSS_CYC);

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  jabber_abort_a: assert property (jab_hit && nib_take |=> !act_q)
    else $error("transmission kept going in jabber");
  idle_link_pulse_a: assert property (!act_q && !tx_en && nlp_tmr_q == 32'h0000_0000 && enable
    |=> tx_drive && tx_line)
    else $error("no link pulse while transmit idle");
  polarity_flag_a: assert property (bit_done && first_q |=> polarity_reversed_flag == !$past(rx_line))
    else $error("polarity flag does not follow first bit");
endmodule

// ==== verilog/ethernet_phy_line_coding.sv ====
// Purpose: Digital line coding for a 10/100 twisted-pair PHY between the MII and the analog front end
// Assumes: 100M path moves one code bit per sys_clk; ADC samples and 10M line levels are synchronous
// Notes: Mode pins replace the management register bits; no software-visible registers
// Contract
// - Code group 10000 is invalid and raises receive error during a frame.
// - Transmit scrambler also serialises each five-bit group.
// - Scrambled bits become an NRZI stream before line coding.
// - Three-level code changes level on a one and holds on a zero.
// - Receive path takes one six-bit quantiser sample per line sample.
// - Descrambler locks its key during idle and then descrambles with it.
// - Descrambler undoes scrambling and packs serial bits into five-bit groups.
// - No idle within the 40 us window aborts reception and restarts lock.
// - Descrambler bypass input skips descrambling.
// - J/K pair fixes group boundaries until the next frame start.
// - J/K delivers two 0101 preamble nibbles with data valid raised.
// - T/R or two idles drop carrier and data valid, never as data.
// - Unexpected groups in a frame raise receive error.
// - Bad start delimiter gives receive error, nibble 1110, no data valid.
// - 10M transmit takes nibbles at 2.5 MHz and serialises them.
// - Transmit nibble is captured at the sys_clk edge after the transmit clock rises while enabled.
// - Manchester cells run at the 20 MHz half-bit rate.
// - Transmit enable low in 10M sends normal link pulses.
// - 10M receive checks Manchester, fixes swapped polarity, flags it.
// - 10M received bits are packed into nibbles for the MAC.
// - Received link pulses keep the 10M link up.
// - Jabber aborts transmission within 45 ms, cleared when enable drops.
// - Transmit data nibbles map through the standard 4B/5B table.
// - Encoder bypass sends transmit error as the fifth bit.
// - J/K on enable rise, T/R on fall, H on error rise.
`timescale 1ns/1ps
module ethernet_phy_line_coding
  import phy_line_pkg::*;
#(
  parameter int NLP_PERIOD_CYC = NLP_PERIOD_CYC_DEF,
  parameter int JABBER_CYC = JABBER_CYC_DEF,
  parameter int LINK_LOSS_CYC = LINK_LOSS_CYC_DEF
)
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic speed_100,
  input wire logic enc_enable,
  input wire logic descr_bypass,
  output logic mii_tx_clk,
  input wire logic [3:0] txd,
  input wire logic tx_en,
  input wire logic tx_er,
  output logic mii_rx_clk,
  output logic [3:0] rxd,
  output logic rx_dv,
  output logic rx_er,
  output logic crs,
  output logic mlt3_pos,
  output logic mlt3_neg,
  input wire logic [5:0] adc_sample,
  output logic descr_locked,
  output logic tx10_line,
  output logic tx10_drive,
  input wire logic rx10_line,
  input wire logic rx10_active,
  output logic polarity_reversed_flag,
  output logic link10_up,
  output logic jabber
);
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // 100M transmit: encode, scramble, serialise, NRZI, MLT-3
  typedef enum logic [1:0] {TX_IDLE, TX_K, TX_DATA, TX_R} tx_state_t;
  tx_state_t tx_state_q;
  tx_state_t tx_state_d;
  logic [2:0] tx_ph_q;
  logic tx_er_q;
  logic [4:0] tx_shift_q;
  logic [4:0] tx_grp_d;
  logic [10:0] scr_q;
  logic nrzi_q;
  logic [1:0] mlt_q;
  logic mlt_pos_q;
  logic mlt_neg_q;
  wire tx_load = tx_ph_q == 3'h0;
  wire scr_key = scr_q[10] ^ scr_q[8];
  wire tx_sbit = tx_shift_q[4] ^ scr_key;
  wire nrzi_d = nrzi_q ^ tx_sbit;
  wire [1:0] mlt_d = (nrzi_d != nrzi_q) ? mlt_q + 2'h1 : mlt_q;

  always_comb
  begin
    tx_grp_d = CG_I;
    tx_state_d = tx_state_q;
    if (!enc_enable)
    begin
      tx_grp_d = {tx_er, txd};
      tx_state_d = TX_IDLE;
    end
    else
    begin
      unique case (tx_state_q)
        TX_IDLE:
        begin
          if (tx_en)
          begin
            tx_grp_d = CG_J;
            tx_state_d = TX_K;
          end
        end
        TX_K:
        begin
          tx_grp_d = CG_K;
          tx_state_d = TX_DATA;
        end
        TX_DATA:
        begin
          if (!tx_en)
          begin
            tx_grp_d = CG_T;
            tx_state_d = TX_R;
          end
          else if (tx_er && !tx_er_q)
          begin
            tx_grp_d = CG_H;
          end
          else
          begin
            tx_grp_d = enc4b5b(txd);
          end
        end
        TX_R:
        begin
          tx_grp_d = CG_R;
          tx_state_d = TX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      tx_state_q <= TX_IDLE;
      tx_ph_q <= 3'h0;
      tx_er_q <= 1'b0;
      tx_shift_q <= CG_I;
      scr_q <= SCR_SEED;
      nrzi_q <= 1'b0;
      mlt_q <= 2'h0;
      mlt_pos_q <= 1'b0;
      mlt_neg_q <= 1'b0;
    end
    else
    begin
      tx_ph_q <= (tx_ph_q == SYM_LAST) ? 3'h0 : tx_ph_q + 3'h1;
      if (tx_load)
      begin
        tx_state_q <= tx_state_d;
        tx_er_q <= tx_er;
        tx_shift_q <= tx_grp_d;
      end
      else
      begin
        tx_shift_q <= {tx_shift_q[3:0], 1'b0};
      end
      scr_q <= {scr_q[9:0], scr_key};
      nrzi_q <= nrzi_d;
      mlt_q <= mlt_d;
      mlt_pos_q <= speed_100 && mlt_d == LVL_POS;
      mlt_neg_q <= speed_100 && mlt_d == LVL_NEG;
    end
  end

  assign mlt3_pos = mlt_pos_q;
  assign mlt3_neg = mlt_neg_q;

  // 100M receive: slice, MLT-3 to NRZI, descramble, align, decode
  typedef enum logic [1:0] {RX_IDLE, RX_SSD_K, RX_FRAME, RX_BAD} rx_state_t;
  rx_state_t rx_state_q;
  logic [1:0] lvl_q;
  logic rx_nrzi_q;
  logic rx_nrzi_prev_q;
  logic [10:0] dsc_q;
  logic [5:0] match_q;
  logic locked_q;
  logic [3:0] ones_q;
  logic [IDLE_TMR_W-1:0] idle_tmr_q;
  logic [9:0] win_q;
  logic [2:0] rx_ph_q;
  logic [3:0] hold_q;
  logic t_seen_q;
  logic i_seen_q;
  logic [3:0] rxd_q;
  logic dv_q;
  logic er_q;
  logic crs_q;
  wire signed [5:0] smp = $signed(adc_sample);
  wire [1:0] lvl_d = (smp >= MLT3_THRESH) ? LVL_POS : ((smp <= MLT3_THRESH_NEG) ? LVL_NEG : LVL_ZERO);
  wire raw_bit = rx_nrzi_q ^ rx_nrzi_prev_q;
  wire dsc_key = dsc_q[10] ^ dsc_q[8];
  wire plain_bit = descr_bypass ? raw_bit : raw_bit ^ dsc_key;
  wire rx_usable = descr_bypass || locked_q;
  wire idle_seen = ones_q >= IDLE_RUN;
  wire idle_expire = !descr_bypass && locked_q && idle_tmr_q == IDLE_TMR_W'(IDLE_WINDOW_CYC - 1);
  wire [9:0] win_d = {win_q[8:0], plain_bit};
  wire [4:0] grp = win_d[4:0];
  wire grp_end = rx_ph_q == SYM_LAST;
  wire [4:0] dec = dec5b4b(grp);
  wire j_found = rx_usable && grp == CG_J && win_d[9:5] == CG_I;

  always_ff @(posedge sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      lvl_q <= LVL_ZERO;
      rx_nrzi_q <= 1'b0;
      rx_nrzi_prev_q <= 1'b0;
      dsc_q <= SCR_SEED;
      match_q <= 6'h00;
      locked_q <= 1'b0;
      ones_q <= 4'h0;
      idle_tmr_q <= '0;
      win_q <= 10'h000;
    end
    else
    begin
      lvl_q <= lvl_d;
      rx_nrzi_q <= rx_nrzi_q ^ (lvl_d != lvl_q);
      rx_nrzi_prev_q <= rx_nrzi_q;
      win_q <= win_d;
      ones_q <= plain_bit ? (idle_seen ? ones_q : ones_q + 4'h1) : 4'h0;
      idle_tmr_q <= (idle_seen || !locked_q) ? '0 : idle_tmr_q + IDLE_TMR_W'(1);
      if (idle_expire)
      begin
        locked_q <= 1'b0;
        match_q <= 6'h00;
      end
      else if (locked_q)
      begin
        dsc_q <= {dsc_q[9:0], dsc_key};
      end
      else
      begin
        // Idle is all ones, so the inverted line bit is the key
        dsc_q <= {dsc_q[9:0], !raw_bit};
        match_q <= (dsc_key == !raw_bit) ? match_q + 6'h01 : 6'h00;
        locked_q <= match_q == LOCK_MATCHES;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      rx_state_q <= RX_IDLE;
      rx_ph_q <= 3'h0;
      hold_q <= NIB_PREAMBLE;
      t_seen_q <= 1'b0;
      i_seen_q <= 1'b0;
      rxd_q <= 4'h0;
      dv_q <= 1'b0;
      er_q <= 1'b0;
      crs_q <= 1'b0;
    end
    else
    begin
      rx_ph_q <= (grp_end || (rx_state_q == RX_IDLE && j_found)) ? 3'h0 : rx_ph_q + 3'h1;
      if (idle_expire)
      begin
        rx_state_q <= RX_IDLE;
        dv_q <= 1'b0;
        er_q <= 1'b0;
        crs_q <= 1'b0;
      end
      else
      begin
        unique case (rx_state_q)
          RX_IDLE:
          begin
            if (j_found)
            begin
              rx_state_q <= RX_SSD_K;
              hold_q <= NIB_PREAMBLE;
              t_seen_q <= 1'b0;
              i_seen_q <= 1'b0;
              crs_q <= 1'b1;
            end
          end
          RX_SSD_K:
          begin
            if (grp_end && grp == CG_K)
            begin
              rx_state_q <= RX_FRAME;
              rxd_q <= hold_q;
              dv_q <= 1'b1;
            end
            else if (grp_end)
            begin
              rx_state_q <= RX_BAD;
              rxd_q <= NIB_BAD_SSD;
              er_q <= 1'b1;
            end
          end
          RX_BAD:
          begin
            if (idle_seen)
            begin
              rx_state_q <= RX_IDLE;
              er_q <= 1'b0;
              crs_q <= 1'b0;
            end
          end
          RX_FRAME:
          begin
            if (grp_end)
            begin
              i_seen_q <= grp == CG_I;
              t_seen_q <= grp == CG_T;
              rxd_q <= hold_q;
              er_q <= 1'b0;
              if ((t_seen_q && grp == CG_R) || (i_seen_q && grp == CG_I))
              begin
                rx_state_q <= RX_IDLE;
                dv_q <= 1'b0;
                crs_q <= 1'b0;
              end
              else if (dec[4] && !t_seen_q)
              begin
                hold_q <= dec[3:0];
              end
              else if (grp != CG_T && grp != CG_I)
              begin
                er_q <= 1'b1;
              end
            end
          end
        endcase
      end
    end
  end

  assign descr_locked = locked_q;

  // 10M path
  logic tx10_clk;
  logic rx10_clk;
  logic [3:0] rxd10;
  logic dv10;
  logic er10;

  tenbase_t_coding #(
    .NLP_PERIOD_CYC(NLP_PERIOD_CYC),
    .JABBER_CYC(JABBER_CYC),
    .LINK_LOSS_CYC(LINK_LOSS_CYC)
  ) u_ten (
    .sys_clk(sys_clk),
    .rst_n(rst_n_q),
    .enable(!speed_100),
    .txd(txd),
    .tx_en(tx_en),
    .tx_clk(tx10_clk),
    .tx_line(tx10_line),
    .tx_drive(tx10_drive),
    .rx_line(rx10_line),
    .rx_active(rx10_active),
    .rx_clk(rx10_clk),
    .rxd(rxd10),
    .rx_dv(dv10),
    .rx_er(er10),
    .polarity_reversed_flag(polarity_reversed_flag),
    .link_up(link10_up),
    .jabber(jabber)
  );

  assign mii_tx_clk = speed_100 ? tx_ph_q < MII_CLK_RISE : tx10_clk;
  assign mii_rx_clk = speed_100 ? rx_ph_q >= MII_CLK_RISE : rx10_clk;
  assign rxd = speed_100 ? rxd_q : rxd10;
  assign rx_dv = speed_100 ? dv_q : dv10;
  assign rx_er = speed_100 ? er_q : er10;
  assign crs = speed_100 ? crs_q : dv10;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n_q);
  invalid_group_err_a: assert property (rx_state_q == RX_FRAME && grp_end && grp == CG_INVALID && !idle_expire
    |=> rx_er && rx_dv)
    else $error("invalid group in frame without receive error");
  bad_ssd_code_a: assert property (rx_state_q == RX_SSD_K && grp_end && grp != CG_K && !idle_expire && speed_100
    |=> rx_er && rxd == NIB_BAD_SSD && !rx_dv)
    else $error("bad start delimiter not reported");
  ssd_preamble_a: assert property (rx_state_q == RX_SSD_K && grp_end && grp == CG_K && !idle_expire
    |=> dv_q && rxd_q == NIB_PREAMBLE ##5 dv_q && rxd_q == NIB_PREAMBLE)
    else $error("start delimiter did not give two preamble nibbles");
  end_of_stream_a: assert property (rx_state_q == RX_FRAME && grp_end && t_seen_q && grp == CG_R
    |=> !dv_q && !crs_q)
    else $error("end delimiter kept data valid");
  mlt3_level_a: assert property (tx_sbit |=> mlt_q != $past(mlt_q))
    else $error("one bit without level change");
  mlt3_hold_a: assert property (!tx_sbit |=> $stable(mlt_q))
    else $error("zero bit changed the level");
  idle_timeout_a: assert property (idle_expire |=> !locked_q && rx_state_q == RX_IDLE)
    else $error("idle window expiry did not restart lock");
  start_code_a: assert property (tx_load && enc_enable && tx_state_q == TX_IDLE && tx_en
    |=> tx_shift_q == CG_J ##5 tx_shift_q == CG_K)
    else $error("frame start did not send J then K");
endmodule

// ==== verif/mii_mac_model.sv ====
// Purpose: MAC side of the internal MII transmit bus
// Assumes: A nibble is taken at the sys_clk edge after mii_tx_clk rises
// Notes: tx_er is the fifth code bit when the encoder is bypassed
`timescale 1ns/1ps
module mii_mac_model
(
  input wire logic sys_clk,
  input wire logic mii_tx_clk,
  output logic [3:0] txd,
  output logic tx_en,
  output logic tx_er
);
  initial
  begin
    txd = 4'h0;
    tx_en = 1'b0;
    tx_er = 1'b0;
  end

  // Drive on the transmit clock rise, hold through the capture edge
  task automatic send(input logic [3:0] nib, input logic err);
    @(posedge mii_tx_clk);
    txd <= nib;
    tx_er <= err;
    tx_en <= 1'b1;
    @(posedge sys_clk);
  endtask

  task automatic stop();
    @(posedge mii_tx_clk);
    tx_en <= 1'b0;
    tx_er <= 1'b0;
    @(posedge sys_clk);
  endtask
endmodule

// ==== verif/ethernet_phy_line_coding_bench.sv ====
// Purpose: Self-checking bench with line loopback for both speeds
// Assumes: Shortened link pulse, jabber and link loss counts
// Notes: Expected nibbles are queued by the driver, popped by the monitor
`timescale 1ns/1ps
module ethernet_phy_line_coding_bench;
  import phy_line_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic speed_100 = 1'b1;
  logic enc_enable = 1'b1;
  logic descr_bypass = 1'b0;
  logic inv = 1'b0;
  logic saw_er = 1'b0;
  logic [3:0] txd, rxd;
  logic tx_en, tx_er, mii_tx_clk, mii_rx_clk, rx_dv, rx_er, crs, mlt3_pos, mlt3_neg, descr_locked;
  logic tx10_line, tx10_drive, rx10_line, rx10_active, polarity_reversed_flag, link10_up, jabber;
  logic [5:0] adc_sample;
  logic [7:0] rnd = 8'h2c;
  logic [3:0] exp_q[$];
  int failures = 0;
  int checks = 0;
  int cyc = 0;

  always #12.5 sys_clk = ~sys_clk;
  // Line loopback: sliced levels back into both receivers
  assign adc_sample = mlt3_pos ? 6'h1f : (mlt3_neg ? 6'h21 : 6'h00);
  assign rx10_line = tx10_line ^ inv;
  assign rx10_active = tx10_drive;

  ethernet_phy_line_coding #(.NLP_PERIOD_CYC(200), .JABBER_CYC(300), .LINK_LOSS_CYC(500)) uut
  (
    .sys_clk(sys_clk), .nrst(nrst), .speed_100(speed_100), .enc_enable(enc_enable),
    .descr_bypass(descr_bypass), .mii_tx_clk(mii_tx_clk), .txd(txd), .tx_en(tx_en), .tx_er(tx_er),
    .mii_rx_clk(mii_rx_clk), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .crs(crs),
    .mlt3_pos(mlt3_pos), .mlt3_neg(mlt3_neg), .adc_sample(adc_sample), .descr_locked(descr_locked),
    .tx10_line(tx10_line), .tx10_drive(tx10_drive), .rx10_line(rx10_line), .rx10_active(rx10_active),
    .polarity_reversed_flag(polarity_reversed_flag), .link10_up(link10_up), .jabber(jabber)
  );

  mii_mac_model mac
  (
    .sys_clk(sys_clk), .mii_tx_clk(mii_tx_clk), .txd(txd), .tx_en(tx_en), .tx_er(tx_er)
  );

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
    checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask

  task automatic close_out();
    if (failures == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic data_frame(input int n);
    for (int i = 0; i < n; i++)
    begin
      rnd = lfsr(rnd);
      exp_q.push_back(rnd[3:0]);
      mac.send(rnd[3:0], 1'b0);
    end
  endtask

  // Monitor: one nibble per receive clock, sampled once settled
  always
  begin
    @(posedge mii_rx_clk);
    @(negedge sys_clk);
    if (rx_dv === 1'b1 && exp_q.size() > 0)
      check("rxd", exp_q.pop_front(), rxd);
  end

  always @(posedge sys_clk)
  begin
    if (rx_er === 1'b1 && rx_dv === 1'b1)
      saw_er <= 1'b1;
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      close_out();
    end
  end

  initial
  begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 3000 && descr_locked !== 1'b1; i++)
      @(posedge sys_clk);
    check("locked", 4'h1, {3'h0, descr_locked});
    exp_q.push_back(NIB_PREAMBLE);
    exp_q.push_back(NIB_PREAMBLE);
    mac.send(4'h5, 1'b0);
    mac.send(4'h5, 1'b0);
    data_frame(8);
    enc_enable <= 1'b0;
    exp_q.push_back(4'h6);
    mac.send(4'he, 1'b0);
    mac.send(4'h0, 1'b1);
    mac.stop();
    enc_enable <= 1'b1;
    repeat (60) @(posedge sys_clk);
    check("rx_er", 4'h1, {3'h0, saw_er});
    check("crs_dv", 4'h0, {2'h0, crs, rx_dv});
    check("left", 4'h0, 4'(exp_q.size()));
    speed_100 <= 1'b0;
    repeat (600) @(posedge sys_clk);
    check("link", 4'h1, {3'h0, link10_up});
    for (int k = 0; k < 2; k++)
    begin
      inv <= k[0];
      exp_q.push_back(NIB_PREAMBLE);
      mac.send(NIB_PREAMBLE, 1'b0);
      data_frame(7);
      mac.stop();
      repeat (40) @(posedge sys_clk);
      check("polarity", {3'h0, k[0]}, {3'h0, polarity_reversed_flag});
      check("left", 4'h0, 4'(exp_q.size()));
    end
    inv <= 1'b0;
    for (int i = 0; i < 24; i++)
      mac.send(4'h5, 1'b0);
    check("jabber", 4'h1, {3'h0, jabber});
    mac.stop();
    repeat (4) @(posedge sys_clk);
    check("jabber", 4'h0, {3'h0, jabber});
    close_out();
  end
endmodule
